//--- sim/test_led_level_sink_ctrl.sv
`timescale 1ns/1ps
module test_led_level_sink_ctrl
    import sink_blink_pkg::*;
;
    localparam int TICK = 10;     // short tick keeps blink intervals small
    localparam int LIMIT = 20000; // far above the thousand or so cycles needed

    logic                 hclk;
    logic                 hresetn;
    logic                 hsel;
    logic [31:0]          haddr;
    logic [1:0]           htrans;
    logic                 hwrite;
    logic [2:0]           hsize;
    logic [31:0]          hwdata;
    logic                 hreadyout;
    logic                 hresp;
    logic [31:0]          hrdata;
    logic [2:0]           ambient_level;
    logic                 dim_timeout;
    logic [CODE_W-1:0]    backlight_code;
    logic [14:0]          backlight_ua;
    logic                 backlight_dimmed;
    logic [1:0]           sink_fade_law_sel;
    logic                 fade_law_cubic;
    logic [NUM_SINKS-1:0] sink_on_out;
    int                   err_count;
    int                   total_checks;
    int                   cycles;
    int                   n;
    logic [31:0]          rd;
    logic [7:0]           ridx [9];
    logic [7:0]           rmask [9];
    logic [6:0]           mx [3];
    logic [6:0]           dm [3];

    led_level_sink_ctrl #(.TICK_CYCLES(TICK)) DUT (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .ambient_level(ambient_level),
        .dim_timeout(dim_timeout), .backlight_code(backlight_code),
        .backlight_ua(backlight_ua), .backlight_dimmed(backlight_dimmed),
        .sink_fade_law_sel(sink_fade_law_sel),
        .fade_law_cubic(fade_law_cubic), .sink_on_out(sink_on_out));

    // free running clock, 8 ns period
    always #4 hclk = ~hclk;

    // watchdog: a hang counts as a mismatch
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            err_count++;
            tally_and_finish();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    // one single AHB transfer; hready is the slave's own hreadyout
    task automatic bus(input logic wr, input logic [7:0] idx,
                       input logic [31:0] wd, output logic [31:0] data);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {22'h0, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hsel   <= 1'b0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        data = hrdata;
        check({31'h0, hresp}, 32'h0);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] dummy;
        bus(1'b1, idx, d, dummy);
    endtask

    task automatic cyc(input int k);
        repeat (k) @(negedge hclk);
    endtask

    // length of the next run of sink bit b at level v, in clocks;
    // call at a negedge so back to back runs lose no cycle
    task automatic run_len(input int b, input logic v, output int len);
        len = 0;
        while (sink_on_out[b] !== v) @(negedge hclk);
        while (sink_on_out[b] === v) begin
            len++;
            @(negedge hclk);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        hclk = 0; hresetn = 0; hsel = 0; haddr = '0; htrans = '0;
        hwrite = 0; hsize = 3'h2; hwdata = '0; ambient_level = 3'h0;
        dim_timeout = 0; err_count = 0; total_checks = 0; cycles = 0;
        ridx = '{IDX_LEVEL3_MAX, IDX_LEVEL3_DIM, IDX_LEVEL4_MAX,
                 IDX_LEVEL4_DIM, IDX_LEVEL5_MAX, IDX_LEVEL5_DIM,
                 IDX_FADE_LAW, IDX_SINK_ENABLE, IDX_TIMING_ONE};
        rmask = '{8'h7f, 8'h7f, 8'h7f, 8'h7f, 8'h7f, 8'h7f,
                  8'h03, 8'h7f, 8'hff};
        mx = '{7'h7f, 7'h11, 7'h33};
        dm = '{7'h00, 7'h22, 7'h44};
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;

        // register map: reset zero, reserved bits read zero
        for (int i = 0; i < 9; i++) begin
            bus(1'b0, ridx[i], 32'h0, rd);
            check(rd, 32'h0);
            wr(ridx[i], 32'hffff_ffff);
            bus(1'b0, ridx[i], 32'h0, rd);
            check(rd, {24'h0, rmask[i]});
            wr(ridx[i], 32'h0);
        end
        wr(8'h30, 32'hff);
        bus(1'b0, 8'h30, 32'h0, rd);
        check(rd, 32'h0);
        $display("test registers done");

        // fade law field, every code; cubic flag follows bit 1
        for (int c = 0; c < 4; c++) begin
            wr(IDX_FADE_LAW, 32'(c));
            cyc(2);
            check(32'(sink_fade_law_sel), 32'(c));
            check(32'(fade_law_cubic), 32'(c >> 1));
        end
        $display("test fade law done");

        // per-level max and dim codes, via timeout pin and host request
        for (int i = 0; i < 3; i++) begin
            wr(IDX_LEVEL3_MAX + 8'(2 * i), 32'(mx[i]));
            wr(IDX_LEVEL3_DIM + 8'(2 * i), 32'(dm[i]));
        end
        for (int i = 0; i < 3; i++) begin
            @(posedge hclk);
            ambient_level <= LEVEL_OFFICE + 3'(i);
            cyc(6);
            check(32'(backlight_code), 32'(mx[i]));
            check(32'(backlight_dimmed), 32'h0);
            @(posedge hclk);
            dim_timeout <= 1'b1;
            cyc(6);
            check(32'(backlight_code), 32'(dm[i]));
            check(32'(backlight_dimmed), 32'h1);
            @(posedge hclk);
            dim_timeout <= 1'b0;
            wr(IDX_DIM_CTRL, 32'h1);
            cyc(4);
            check(32'(backlight_code), 32'(dm[i]));
            wr(IDX_DIM_CTRL, 32'h0);
            cyc(4);
            check(32'(backlight_code), 32'(mx[i]));
        end
        // square-law end points: full code gives full scale, zero gives none
        @(posedge hclk);
        ambient_level <= LEVEL_OFFICE;
        cyc(6);
        check(32'(backlight_ua), 32'(FULL_SCALE_UA));
        wr(IDX_DIM_CTRL, 32'h1);
        cyc(4);
        check(32'(backlight_ua), 32'h0);
        wr(IDX_DIM_CTRL, 32'h0);
        $display("test backlight done");

        // blink: on 00, sink7 off 01, sink6 steady, sink5 off 11
        wr(IDX_TIMING_ONE, 32'h0000_0013);
        wr(IDX_SINK_ENABLE, 32'h0000_0071);
        cyc(3);
        check(32'(sink_on_out), 32'h71);
        run_len(6, 1'b0, n);
        check(32'(n), 32'((OFF_MS_01 / TICK_MS) * TICK));
        run_len(6, 1'b1, n);
        check(32'(n), 32'((ON_MS_00 / TICK_MS) * TICK));
        check(32'(sink_on_out[5]), 32'h1);
        check(32'(sink_on_out[0]), 32'h1);
        // sink5 is mid-gap here: skip to its next lit run, then a full gap
        run_len(4, 1'b1, n);
        check(32'(n), 32'((ON_MS_00 / TICK_MS) * TICK));
        run_len(4, 1'b0, n);
        check(32'(n), 32'((OFF_MS_11 / TICK_MS) * TICK));
        // sink7 re-enabled with on time 11 lights at once, then blinks
        wr(IDX_SINK_ENABLE, 32'h0);
        cyc(2);
        check(32'(sink_on_out), 32'h0);
        wr(IDX_TIMING_ONE, 32'h0000_00e0);
        wr(IDX_SINK_ENABLE, 32'h0000_0040);
        cyc(2);
        check(32'(sink_on_out), 32'h40);
        run_len(6, 1'b0, n);
        check(32'(n), 32'((OFF_MS_10 / TICK_MS) * TICK));
        run_len(6, 1'b1, n);
        check(32'(n), 32'((ON_MS_11 / TICK_MS) * TICK));
        $display("test blink done");
        tally_and_finish();
    end
endmodule

//--- src/blink_timer.sv
`timescale 1ns/1ps
module blink_timer
    import sink_blink_pkg::*;
(
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic             tick,
    input  wire logic             enable,
    input  wire logic [CNT_W-1:0] on_len,
    input  wire logic [1:0]       off_code,
    output logic                  sink_on
);
    typedef enum logic [1:0] {IDLE, LIT, DARK} phase_t;

    typedef struct packed {
        phase_t           phase;
        logic [CNT_W-1:0] cnt;
        logic             en_d;
    } timer_state_t;

    timer_state_t     st_ff;
    timer_state_t     nxt_st;
    logic [CNT_W-1:0] cnt_inc;

    // on/off sequencer; counts slow ticks, not clocks
    always_comb begin
        nxt_st = st_ff;
        nxt_st.en_d = enable;
        cnt_inc = st_ff.cnt + CNT_W'(1);
        if (!enable) begin
            nxt_st.phase = IDLE;
            nxt_st.cnt = '0;
        end else if (!st_ff.en_d) begin
            nxt_st.phase = LIT;
            nxt_st.cnt = '0;
        end else begin
            unique case (st_ff.phase)
                IDLE: begin
                    nxt_st.phase = LIT;
                    nxt_st.cnt = '0;
                end
                LIT: begin
                    if (off_code == 2'h0) begin
                        nxt_st.cnt = '0;
                    end else if (tick) begin
                        if (cnt_inc >= on_len) begin
                            nxt_st.phase = DARK;
                            nxt_st.cnt = '0;
                        end else begin
                            nxt_st.cnt = cnt_inc;
                        end
                    end
                end
                DARK: begin
                    // clearing the off time mid-gap relights at once
                    if (off_code == 2'h0) begin
                        nxt_st.phase = LIT;
                        nxt_st.cnt = '0;
                    end else if (tick) begin
                        if (cnt_inc >= off_ticks(off_code)) begin
                            nxt_st.phase = LIT;
                            nxt_st.cnt = '0;
                        end else begin
                            nxt_st.cnt = cnt_inc;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff <= '{phase: IDLE, cnt: '0, en_d: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign sink_on = (st_ff.phase == LIT);

    sequence s_lit_expires;
        enable && st_ff.en_d && st_ff.phase == LIT && tick &&
        off_code != 2'h0 && cnt_inc >= on_len;
    endsequence

    sequence s_dark_expires;
        enable && st_ff.en_d && st_ff.phase == DARK && tick &&
        off_code != 2'h0 && cnt_inc >= off_ticks(off_code);
    endsequence

    AST_RISE_LIGHTS: assert property (@(posedge hclk) disable iff (!hresetn)
        (enable && !st_ff.en_d) |=> sink_on && st_ff.cnt == '0)
        else $error("enable rise did not light sink");
    AST_DISABLE_DARK: assert property (@(posedge hclk) disable iff (!hresetn)
        !enable |=> !sink_on)
        else $error("disabled sink still lit");
    AST_STEADY_ON: assert property (@(posedge hclk) disable iff (!hresetn)
        (sink_on && enable && off_code == 2'h0) ##1
        (enable && off_code == 2'h0) |-> sink_on)
        else $error("steady sink went dark");
    AST_ON_EXPIRES: assert property (@(posedge hclk) disable iff (!hresetn)
        s_lit_expires |=> !sink_on)
        else $error("on time did not end");
    AST_OFF_EXPIRES: assert property (@(posedge hclk) disable iff (!hresetn)
        s_dark_expires |=> sink_on)
        else $error("off time did not end");
endmodule

//--- src/code_current_map.sv
`timescale 1ns/1ps
module code_current_map
    import sink_blink_pkg::*;
(
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic [CODE_W-1:0] code,
    output logic      [14:0]       current_ua
);
    typedef struct packed {
        logic [14:0] ua;
    } map_state_t;

    map_state_t  st_ff;
    map_state_t  nxt_st;
    logic [13:0] sq;
    logic [28:0] prod;

    // square law; round to nearest microamp
    always_comb begin
        sq = 14'(code) * 14'(code); // widen first so the square is not cut
        prod = 29'(sq) * 29'(FULL_SCALE_UA);
        nxt_st.ua = 15'((prod + 29'(CODE_MAX_SQ >> 1)) / 29'(CODE_MAX_SQ));
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign current_ua = st_ff.ua;

    AST_MAP_ENDS: assert property (@(posedge hclk) disable iff (!hresetn)
        (code == '0 |=> current_ua == '0) and
        (code == '1 |=> current_ua == FULL_SCALE_UA))
        else $error("code end points map wrong");
endmodule

//--- src/led_level_sink_ctrl.sv
`timescale 1ns/1ps
// Operation
// - levels 3, 4, 5 each own a max-current register, code in bits 6:0
// - codes map to current on a square law, zero to full scale
// - dim timeout or host dim request selects the active level's dim code
// - levels 3, 4, 5 each own a dim-current register, code in bits 6:0
// - two-bit fade law field picks square-linear or one of two cubic laws
// - cubic laws reuse the square-law code table, only step timing differs
// - one enable bit per sink, bit 6 down to bit 0, 1 means on
// - with an off time set, an enabled sink stays on for the shared on time
// - off code 00 keeps the sink on steadily; 01,10,11 give 0.6,1.2,1.8 s
// - after its off time a sink relights; cycle repeats while enabled
// - timing register holds on time in 7:6, sink 7,6,5 off times below
module led_level_sink_ctrl
    import sink_blink_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic                      hreadyout,
    output logic                      hresp,
    output logic      [31:0]          hrdata,
    input  wire logic [2:0]           ambient_level,
    input  wire logic                 dim_timeout,
    output logic      [CODE_W-1:0]    backlight_code,
    output logic      [14:0]          backlight_ua,
    output logic                      backlight_dimmed,
    output logic      [1:0]           sink_fade_law_sel,
    output logic                      fade_law_cubic,
    output logic      [NUM_SINKS-1:0] sink_on_out
);
    typedef struct packed {
        // software-visible registers
        logic [CODE_W-1:0]    office_max_code;
        logic [CODE_W-1:0]    office_dim_code;
        logic [CODE_W-1:0]    indoor_max_code;
        logic [CODE_W-1:0]    indoor_dim_code;
        logic [CODE_W-1:0]    dark_max_code;
        logic [CODE_W-1:0]    dark_dim_code;
        logic                 dim_request;
        logic [1:0]           fade_law;
        logic [NUM_SINKS-1:0] sink_enable;
        logic [7:0]           timing_one;
        // bus data phase
        logic                 wr_pend;
        logic [7:0]           wr_idx;
        logic [31:0]          rdata;
        // pin synchronisers
        logic [2:0]           level_meta;
        logic [2:0]           level_sync;
        logic                 dto_meta;
        logic                 dto_sync;
        // backlight selection
        logic [CODE_W-1:0]    code;
        logic                 dimmed;
        // slow tick divider
        logic [TICK_W-1:0]    div_cnt;
        logic                 tick;
    } ctrl_state_t;

    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

    ctrl_state_t          st_ff;
    ctrl_state_t          nxt_st;
    logic                 addr_take;
    logic [7:0]           addr_idx;
    logic [NUM_SINKS-1:0] sink_lit;
    logic [CNT_W-1:0]     on_len;
    logic [1:0]           off_code [NUM_SINKS];
    logic [7:0]           rd_byte;
    logic                 dim_now;

    // a valid transfer is taken only when the bus is ready
    assign addr_take = hsel && hready && htrans[1];
    assign addr_idx  = haddr[9:2];
    assign dim_now   = st_ff.dim_request || st_ff.dto_sync;

    // read view of the register at a given index
    function automatic logic [7:0] read_reg(input ctrl_state_t s,
                                            input logic [7:0] idx,
                                            input logic [NUM_SINKS-1:0] lit);
        logic [7:0] v;
        v = 8'h00;
        case (idx)
            IDX_LEVEL3_MAX:  v = {1'b0, s.office_max_code};
            IDX_LEVEL3_DIM:  v = {1'b0, s.office_dim_code};
            IDX_LEVEL4_MAX:  v = {1'b0, s.indoor_max_code};
            IDX_LEVEL4_DIM:  v = {1'b0, s.indoor_dim_code};
            IDX_LEVEL5_MAX:  v = {1'b0, s.dark_max_code};
            IDX_LEVEL5_DIM:  v = {1'b0, s.dark_dim_code};
            IDX_DIM_CTRL:    v = {7'h00, s.dim_request};
            IDX_SINK_STATUS: v = {s.dimmed, lit};
            IDX_FADE_LAW:    v = {6'h00, s.fade_law};
            IDX_SINK_ENABLE: v = {1'b0, s.sink_enable};
            IDX_TIMING_ONE:  v = s.timing_one;
            default:         v = 8'h00;
        endcase
        return v;
    endfunction

    // bus, registers, synchronisers, selection and divider
    always_comb begin
        nxt_st = st_ff;

        // data phase of a write lands in the register it addressed
        nxt_st.wr_pend = 1'b0;
        if (st_ff.wr_pend) begin
            case (st_ff.wr_idx)
                IDX_LEVEL3_MAX:  nxt_st.office_max_code = hwdata[6:0];
                IDX_LEVEL3_DIM:  nxt_st.office_dim_code = hwdata[6:0];
                IDX_LEVEL4_MAX:  nxt_st.indoor_max_code = hwdata[6:0];
                IDX_LEVEL4_DIM:  nxt_st.indoor_dim_code = hwdata[6:0];
                IDX_LEVEL5_MAX:  nxt_st.dark_max_code = hwdata[6:0];
                IDX_LEVEL5_DIM:  nxt_st.dark_dim_code = hwdata[6:0];
                IDX_DIM_CTRL:    nxt_st.dim_request = hwdata[0];
                IDX_FADE_LAW:    nxt_st.fade_law = hwdata[1:0];
                IDX_SINK_ENABLE: nxt_st.sink_enable = hwdata[6:0];
                IDX_TIMING_ONE:  nxt_st.timing_one = hwdata[7:0];
                default:         nxt_st.wr_pend = 1'b0;
            endcase
        end

        // a read right behind a write sees the new value
        rd_byte = read_reg(nxt_st, addr_idx, sink_lit);

        // address phase: latch write target, fetch read data early
        if (addr_take) begin
            nxt_st.wr_pend = hwrite;
            nxt_st.wr_idx = addr_idx;
            if (!hwrite) begin
                nxt_st.rdata = {24'h000000, rd_byte};
            end
        end

        // pins from outside pass two flops before use
        nxt_st.level_meta = ambient_level;
        nxt_st.level_sync = st_ff.level_meta;
        nxt_st.dto_meta = dim_timeout;
        nxt_st.dto_sync = st_ff.dto_meta;

        // levels outside 3..5 are driven elsewhere; give no current here
        nxt_st.dimmed = dim_now;
        case (st_ff.level_sync)
            LEVEL_OFFICE: nxt_st.code = dim_now ? st_ff.office_dim_code
                                                : st_ff.office_max_code;
            LEVEL_INDOOR: nxt_st.code = dim_now ? st_ff.indoor_dim_code
                                                : st_ff.indoor_max_code;
            LEVEL_DARK:   nxt_st.code = dim_now ? st_ff.dark_dim_code
                                                : st_ff.dark_max_code;
            default:      nxt_st.code = RST_CODE;
        endcase

        // divider: one-cycle tick every TICK_CYCLES clocks
        nxt_st.tick = 1'b0;
        if (st_ff.div_cnt >= TICK_LAST) begin
            nxt_st.div_cnt = '0;
            nxt_st.tick = 1'b1;
        end else begin
            nxt_st.div_cnt = st_ff.div_cnt + TICK_W'(1);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff <= '{office_max_code: RST_CODE, office_dim_code: RST_CODE,
                       indoor_max_code: RST_CODE, indoor_dim_code: RST_CODE,
                       dark_max_code: RST_CODE, dark_dim_code: RST_CODE,
                       dim_request: 1'b0, fade_law: RST_LAW,
                       sink_enable: RST_ENABLE, timing_one: RST_TIMING,
                       wr_pend: 1'b0, wr_idx: 8'h00, rdata: 32'h00000000,
                       level_meta: 3'h0, level_sync: 3'h0,
                       dto_meta: 1'b0, dto_sync: 1'b0,
                       code: RST_CODE, dimmed: 1'b0,
                       div_cnt: '0, tick: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = st_ff.rdata;

    // shared on time and per-sink off times; sinks 1..4 have no off time here
    assign on_len = on_ticks(st_ff.timing_one[7:ON_TIME_LSB]);

    genvar gi;
    generate
        for (gi = 0; gi < NUM_SINKS; gi++) begin : g_sink
            if (gi >= FIRST_OFF_SINK) begin : g_timed
                assign off_code[gi] =
                    st_ff.timing_one[2*(gi-FIRST_OFF_SINK)+1 -: 2];
            end else begin : g_steady
                assign off_code[gi] = 2'h0;
            end
            // all timers see the same write edge, so one write syncs them
            blink_timer u_timer (
                .hclk     (hclk),
                .hresetn  (hresetn),
                .tick     (st_ff.tick),
                .enable   (st_ff.sink_enable[gi]),
                .on_len   (on_len),
                .off_code (off_code[gi]),
                .sink_on  (sink_lit[gi])
            );
        end
    endgenerate

    // backlight current uses the one square-law table for every law
    code_current_map u_map (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .code       (st_ff.code),
        .current_ua (backlight_ua)
    );

    assign backlight_code = st_ff.code;
    assign backlight_dimmed = st_ff.dimmed;
    assign sink_fade_law_sel = st_ff.fade_law;
    assign fade_law_cubic = st_ff.fade_law[1];
    assign sink_on_out = sink_lit;

    sequence s_enable_write;
        st_ff.wr_pend && st_ff.wr_idx == IDX_SINK_ENABLE;
    endsequence

    AST_ENABLE_STORED: assert property (@(posedge hclk) disable iff (!hresetn)
        s_enable_write |=> st_ff.sink_enable == $past(hwdata[6:0]))
        else $error("enable write not stored");
    AST_DIM_PICKED: assert property (@(posedge hclk) disable iff (!hresetn)
        (dim_now && st_ff.level_sync == LEVEL_OFFICE) |=>
        backlight_code == $past(st_ff.office_dim_code))
        else $error("dim code not applied");
    AST_MAX_PICKED: assert property (@(posedge hclk) disable iff (!hresetn)
        (!dim_now && st_ff.level_sync == LEVEL_DARK) |=>
        backlight_code == $past(st_ff.dark_max_code))
        else $error("max code not applied");
    AST_LEVEL_READ: assert property (@(posedge hclk) disable iff (!hresetn)
        (addr_take && !hwrite && !st_ff.wr_pend &&
        addr_idx == IDX_LEVEL4_DIM) |=>
        hrdata == {25'h0, $past(st_ff.indoor_dim_code)})
        else $error("dim register read wrong");
    AST_TICK_SPACING: assert property (@(posedge hclk) disable iff (!hresetn)
        st_ff.tick |=> !st_ff.tick)
        else $error("tick longer than one cycle");
endmodule

//--- src/sink_blink_pkg.sv
package sink_blink_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_LEVEL3_MAX  = 8'h0e;
    localparam logic [7:0] IDX_LEVEL3_DIM  = 8'h0f;
    localparam logic [7:0] IDX_LEVEL4_MAX  = 8'h10;
    localparam logic [7:0] IDX_LEVEL4_DIM  = 8'h11;
    localparam logic [7:0] IDX_LEVEL5_MAX  = 8'h12;
    localparam logic [7:0] IDX_LEVEL5_DIM  = 8'h13;
    localparam logic [7:0] IDX_DIM_CTRL    = 8'h14;
    localparam logic [7:0] IDX_SINK_STATUS = 8'h15;
    localparam logic [7:0] IDX_FADE_LAW    = 8'h1a;
    localparam logic [7:0] IDX_SINK_ENABLE = 8'h1b;
    localparam logic [7:0] IDX_TIMING_ONE  = 8'h1c;

    // field positions
    localparam int CODE_W      = 7;
    localparam int NUM_SINKS   = 7;
    localparam int ON_TIME_LSB = 6;
    localparam int FIRST_OFF_SINK = 4;   // sink5 is index 4

    // reset values
    localparam logic [6:0] RST_CODE   = 7'h00;
    localparam logic [1:0] RST_LAW    = 2'h0;
    localparam logic [6:0] RST_ENABLE = 7'h00;
    localparam logic [7:0] RST_TIMING = 8'h00;

    // ambient levels served here
    localparam logic [2:0] LEVEL_OFFICE = 3'h3;
    localparam logic [2:0] LEVEL_INDOOR = 3'h4;
    localparam logic [2:0] LEVEL_DARK   = 3'h5;

    // current mapping
    localparam logic [14:0] FULL_SCALE_UA = 15'h7530;   // 30000 uA
    localparam logic [13:0] CODE_MAX_SQ   = 14'h3f01;   // 127 squared

    // timing: a slow tick paces every blink interval
    localparam int CLK_KHZ         = 125000;
    localparam int TICK_MS         = 100;
    localparam int TICK_CYCLES_DEF = TICK_MS * CLK_KHZ;
    localparam int TICK_W          = 24;
    localparam int ON_MS_00  = 200;
    localparam int ON_MS_01  = 600;
    localparam int ON_MS_10  = 800;
    localparam int ON_MS_11  = 1200;
    localparam int OFF_MS_01 = 600;
    localparam int OFF_MS_10 = 1200;
    localparam int OFF_MS_11 = 1800;
    localparam int CNT_W     = 5;

    function automatic logic [CNT_W-1:0] on_ticks(input logic [1:0] c);
        case (c)
            2'h0:    on_ticks = CNT_W'(ON_MS_00 / TICK_MS);
            2'h1:    on_ticks = CNT_W'(ON_MS_01 / TICK_MS);
            2'h2:    on_ticks = CNT_W'(ON_MS_10 / TICK_MS);
            default: on_ticks = CNT_W'(ON_MS_11 / TICK_MS);
        endcase
    endfunction

    function automatic logic [CNT_W-1:0] off_ticks(input logic [1:0] c);
        case (c)
            2'h1:    off_ticks = CNT_W'(OFF_MS_01 / TICK_MS);
            2'h2:    off_ticks = CNT_W'(OFF_MS_10 / TICK_MS);
            default: off_ticks = CNT_W'(OFF_MS_11 / TICK_MS);
        endcase
    endfunction

endpackage
